// ### hdl/adc_mode_consts.svh
// Offsets, field positions, reset values and timing counts of the bank
`ifndef ADC_MODE_CONSTS_SVH
`define ADC_MODE_CONSTS_SVH

// ==========================================================
// Register offsets (seven-bit serial address)
`define ADDR_SOFT_RESET      7'h00
`define ADDR_POWER_DOWN      7'h01
`define ADDR_OUTPUT_MODE     7'h02
`define ADDR_PATTERN_HIGH    7'h03
`define ADDR_PATTERN_LOW     7'h04

// ==========================================================
// Field positions
`define SRST_BIT             7
`define SLEEP_BIT            4
`define NAP_MSB              3
`define CURRENT_MSB          7
`define CURRENT_LSB          5
`define TERM_BIT             4
`define OUTPUT_DRIVER_DISABLE_BIT           3
`define LANE_MSB             2
`define LANE_LSB             0
`define PAT_ENABLE_BIT       7
`define PAT_UNUSED_BIT       6

// ==========================================================
// Reset values
`define REG_RESET_VALUE      8'h00
`define PD_RESET_VALUE       5'h00

// ==========================================================
// Serial word and timing
`define WORD_BITS            16
`define HEADER_BITS          8
`define CLK_PERIOD_PS        8000
`define SRST_TIME_NS         100
`define SRST_CYCLES \
  ((`SRST_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ### hdl/adc_mode_pkg.sv
// Types shared by the mode-control register bank
package adc_mode_pkg;

  // ==========================================================
  // Serial word state, one-hot
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_DONE  = 3'b100
  } ser_state_e;

  typedef logic [7:0] reg_byte_t;
  typedef logic [6:0] reg_addr_t;

endpackage

// ### hdl/serial_word_port.sv
// Serial command word receiver and read-back shifter
`timescale 1ns/1ps
`include "adc_mode_consts.svh"

module serial_word_port
  import adc_mode_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst_n,
  // Serial pins
  input  wire logic      cs_n,
  input  wire logic      sck,
  input  wire logic      sdi,
  // Register side
  output reg_addr_t      hdr_addr,
  input  wire reg_byte_t rd_data,
  output reg_addr_t      cmd_addr,
  output reg_byte_t      cmd_data,
  output logic           wr_strobe,
  output logic           sdo_low
);

  // ==========================================================
  // State
  ser_state_e state_r;
  ser_state_e state_nxt;
  logic [14:0] shift_r;
  logic [4:0]  count_r;
  logic        sck_r;
  logic        reading_r;
  reg_byte_t   out_r;
  logic        sdo_bit_r;
  logic        wr_r;

  // Edge detection of the serial clock inside a frame
  wire sck_rise  = sck & ~sck_r & ~cs_n;
  wire sck_fall  = ~sck & sck_r & ~cs_n;
  wire last_bit  = (count_r == 5'(`WORD_BITS - 1));
  wire hdr_bit   = (count_r == 5'(`HEADER_BITS - 1));
  wire in_shift  = (state_r == SER_SHIFT);

  // Header address as bits arrive; command fields after the last shift
  assign hdr_addr  = {shift_r[5:0], sdi};
  assign cmd_addr  = shift_r[14:8];
  assign cmd_data  = shift_r[7:0];
  assign wr_strobe = wr_r;
  assign sdo_low   = reading_r & ~sdo_bit_r & ~cs_n;

  // Next state; edges past the sixteenth are ignored
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SER_IDLE:  if (!cs_n) state_nxt = SER_SHIFT;
      SER_SHIFT: begin
        if (cs_n) state_nxt = SER_IDLE;
        else if (sck_rise && last_bit) state_nxt = SER_DONE;
      end
      SER_DONE:  if (cs_n) state_nxt = SER_IDLE;
      default:   state_nxt = SER_IDLE;
    endcase
  end

  // State, bit count and input shifter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SER_IDLE;
      count_r <= 5'h0;
      shift_r <= 15'h0;
      sck_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sck_r   <= sck;
      if (state_r == SER_IDLE) count_r <= 5'h0;
      else if (in_shift && sck_rise) count_r <= count_r + 5'h1;
      if (in_shift && sck_rise) shift_r <= {shift_r[13:0], sdi};
    end
  end

  // Write pulse on the sixteenth edge of a write word (see R13)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) wr_r <= 1'b0;
    else wr_r <= in_shift & sck_rise & last_bit & ~shift_r[14];
  end

  // Read-back: load at the header, shift out on falling edges (see R13)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reading_r <= 1'b0;
      out_r     <= 8'h00;
      sdo_bit_r <= 1'b1;
    end else if (cs_n) begin
      reading_r <= 1'b0;
      sdo_bit_r <= 1'b1;
    end else if (in_shift && sck_rise && hdr_bit) begin
      reading_r <= shift_r[6];
      out_r     <= rd_data;
    end else if (reading_r && sck_fall) begin
      sdo_bit_r <= out_r[7];
      out_r     <= {out_r[6:0], 1'b1};
    end
  end

endmodule

// ### hdl/adc_mode_control_registers.sv
// Mode-control register bank of a four-channel serial-output converter
//
// How it works
// R1: With sleep clear, power-down bits 3..0 nap channels 4..1 freely.
// R2: Power-down bit 4 sleeps every channel; all zero is normal operation.
// R3: Driver current codes 000, 001, 010 give 3.5, 4.0 and 4.5 mA.
// R4: Codes 100..111 give 3.0, 2.5, 2.1, 1.75 mA; code 011 is reserved.
// R5: Output-mode bit 4 switches the internal output termination on.
// R6: Lane codes 000, 001, 010 give two lanes at 16, 14 and 12 bits.
// R7: Lane codes 011 and 100 are unused; 101..111 give one lane.
// R8: Test-pattern high bit 7 swaps converted data for the pattern.
// R9: Test-pattern high bits 5..0 form output data bits 11 down to 6.
// R10: Test-pattern low bits 7..2 form output data bits 5 down to 0.
// R11: Test-pattern low bits 1..0 form the two extra compatibility bits.
// R12: Test-pattern high bit 6 is unused and has no effect.
// R13: Each access is a 16-bit word: read flag, 7-bit address, 8 data bits.
// R14: Soft reset clears every mode register and sleeps the part briefly.
// R15: Output-mode bit 3 disables the digital output drivers.
// R16: Fields act once the write word ends; read-back returns the fields.
`timescale 1ns/1ps
`include "adc_mode_consts.svh"

module adc_mode_control_registers
  import adc_mode_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int DATA_W   = 12,
  parameter int EXTRA_W  = 2
)
(
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  // Serial configuration pins
  input  wire logic                              cs_n,
  input  wire logic                              sck,
  input  wire logic                              sdi,
  output logic                                   sdo_out,
  output logic                                   sdo_oe,
  // Converter samples in
  input  wire logic [CHANNELS*DATA_W-1:0]        sample_in,
  // Output data after pattern and power gating
  output logic [CHANNELS*(DATA_W+EXTRA_W)-1:0]   sample_out,
  // Power control
  output logic [CHANNELS-1:0]                    channel_nap,
  output logic                                   converter_sleep,
  output logic                                   soft_reset_busy,
  // Output driver control
  output logic [2:0]                             driver_current_select,
  output logic [12:0]                            driver_current_ua,
  output logic                                   current_code_reserved,
  output logic                                   internal_termination_enable,
  output logic                                   output_driver_disable,
  // Lane and serialization control
  output logic [2:0]                             lane_serialization_select,
  output logic                                   two_lane_mode,
  output logic [4:0]                             serial_width,
  output logic                                   lane_code_unused,
  // Test pattern
  output logic                                   pattern_output_enable
);

  localparam int OUT_W = DATA_W + EXTRA_W;

  // ==========================================================
  // Register storage
  logic [4:0]  pd_r;
  reg_byte_t   om_r;
  logic        pat_en_r;
  logic [5:0]  pattern_upper_bits_r;
  logic [5:0]  pattern_lower_bits_r;
  logic        pattern_extra_bit_a_r;
  logic        pattern_extra_bit_b_r;
  logic [7:0]  srst_cnt_r;

  // Serial port wires
  reg_addr_t   hdr_addr;
  reg_byte_t   rd_data;
  reg_addr_t   cmd_addr;
  reg_byte_t   cmd_data;
  logic        wr_strobe;
  logic        sdo_low;

  // ==========================================================
  // Serial word receiver
  serial_word_port u_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .cs_n      (cs_n),
    .sck       (sck),
    .sdi       (sdi),
    .hdr_addr  (hdr_addr),
    .rd_data   (rd_data),
    .cmd_addr  (cmd_addr),
    .cmd_data  (cmd_data),
    .wr_strobe (wr_strobe),
    .sdo_low   (sdo_low)
  );

  // ==========================================================
  // Write decode
  wire hit_reset = (cmd_addr == `ADDR_SOFT_RESET);
  wire hit_pd    = (cmd_addr == `ADDR_POWER_DOWN);
  wire hit_om    = (cmd_addr == `ADDR_OUTPUT_MODE);
  wire hit_tph   = (cmd_addr == `ADDR_PATTERN_HIGH);
  wire hit_tpl   = (cmd_addr == `ADDR_PATTERN_LOW);
  wire wr_pd     = wr_strobe & hit_pd;
  wire wr_om     = wr_strobe & hit_om;
  wire wr_tph    = wr_strobe & hit_tph;
  wire wr_tpl    = wr_strobe & hit_tpl;
  wire srst_go   = wr_strobe & hit_reset & cmd_data[`SRST_BIT];
  wire srst_busy = (srst_cnt_r != 8'h00);

  // ==========================================================
  // Read decode from the header address
  wire rd_reset = (hdr_addr == `ADDR_SOFT_RESET);
  wire rd_pd    = (hdr_addr == `ADDR_POWER_DOWN);
  wire rd_om    = (hdr_addr == `ADDR_OUTPUT_MODE);
  wire rd_tph   = (hdr_addr == `ADDR_PATTERN_HIGH);
  wire rd_tpl   = (hdr_addr == `ADDR_PATTERN_LOW);

  // Read-back of the implemented bits; others read as zero (see R16)
  always_comb begin
    if (rd_reset)
      rd_data = {srst_busy, 7'h00};
    else if (rd_pd)
      rd_data = {3'b000, pd_r};
    else if (rd_om)
      rd_data = om_r;
    else if (rd_tph)
      rd_data = {pat_en_r, 1'b0, pattern_upper_bits_r};
    else if (rd_tpl)
      rd_data = {pattern_lower_bits_r, pattern_extra_bit_a_r,
                 pattern_extra_bit_b_r};
    else
      rd_data = 8'h00;
  end

  // ==========================================================
  // Soft reset timer, clears itself when done
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) srst_cnt_r <= 8'h00;
    else if (srst_go) srst_cnt_r <= 8'(`SRST_CYCLES); // see R14
    else if (srst_busy) srst_cnt_r <= srst_cnt_r - 8'h01;
  end

  // Power-down register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pd_r <= `PD_RESET_VALUE;
    else if (srst_go) pd_r <= `PD_RESET_VALUE; // see R14
    else if (wr_pd) pd_r <= cmd_data[4:0]; // see R13
  end

  // Output-mode register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) om_r <= `REG_RESET_VALUE;
    else if (srst_go) om_r <= `REG_RESET_VALUE; // see R14
    else if (wr_om) om_r <= cmd_data; // see R13
  end

  // Test-pattern high register; bit 6 is not stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pat_en_r             <= 1'b0;
      pattern_upper_bits_r <= 6'h00;
    end else if (srst_go) begin
      pat_en_r             <= 1'b0;
      pattern_upper_bits_r <= 6'h00;
    end else if (wr_tph) begin
      pat_en_r             <= cmd_data[`PAT_ENABLE_BIT];
      pattern_upper_bits_r <= cmd_data[5:0]; // see R9, R12
    end
  end

  // Test-pattern low register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pattern_lower_bits_r  <= 6'h00;
      pattern_extra_bit_a_r <= 1'b0;
      pattern_extra_bit_b_r <= 1'b0;
    end else if (srst_go) begin
      pattern_lower_bits_r  <= 6'h00;
      pattern_extra_bit_a_r <= 1'b0;
      pattern_extra_bit_b_r <= 1'b0;
    end else if (wr_tpl) begin
      pattern_lower_bits_r  <= cmd_data[7:2]; // see R10
      pattern_extra_bit_a_r <= cmd_data[1]; // see R11
      pattern_extra_bit_b_r <= cmd_data[0]; // see R11
    end
  end

  // ==========================================================
  // Power decode: sleep overrides naps, soft reset forces sleep
  wire       sleep_nxt = pd_r[`SLEEP_BIT] | srst_busy | srst_go; // see R2
  wire [CHANNELS-1:0] nap_nxt =
    sleep_nxt ? {CHANNELS{1'b0}} : pd_r[CHANNELS-1:0]; // see R1

  // ==========================================================
  // Driver current decode in microamps
  wire [2:0] cur_code = om_r[`CURRENT_MSB:`CURRENT_LSB];
  logic [12:0] cur_ua_nxt;
  always_comb begin
    case (cur_code)
      3'b000:  cur_ua_nxt = 13'h0DAC; // see R3
      3'b001:  cur_ua_nxt = 13'h0FA0; // see R3
      3'b010:  cur_ua_nxt = 13'h1194; // see R3
      3'b100:  cur_ua_nxt = 13'h0BB8; // see R4
      3'b101:  cur_ua_nxt = 13'h09C4; // see R4
      3'b110:  cur_ua_nxt = 13'h0834; // see R4
      3'b111:  cur_ua_nxt = 13'h06D6; // see R4
      default: cur_ua_nxt = 13'h0DAC;
    endcase
  end
  wire cur_reserved = (cur_code == 3'b011); // see R4

  // ==========================================================
  // Lane and serialization decode
  wire [2:0] lane_code = om_r[`LANE_MSB:`LANE_LSB];
  logic       two_lane_nxt;
  logic [4:0] width_nxt;
  always_comb begin
    case (lane_code)
      3'b000:  begin two_lane_nxt = 1'b1; width_nxt = 5'd16; end // see R6
      3'b001:  begin two_lane_nxt = 1'b1; width_nxt = 5'd14; end // see R6
      3'b010:  begin two_lane_nxt = 1'b1; width_nxt = 5'd12; end // see R6
      3'b101:  begin two_lane_nxt = 1'b0; width_nxt = 5'd14; end // see R7
      3'b110:  begin two_lane_nxt = 1'b0; width_nxt = 5'd16; end // see R7
      3'b111:  begin two_lane_nxt = 1'b0; width_nxt = 5'd16; end // see R7
      default: begin two_lane_nxt = 1'b1; width_nxt = 5'd16; end
    endcase
  end
  wire lane_unused = (lane_code == 3'b011) | (lane_code == 3'b100); // see R7

  // ==========================================================
  // Pattern word: upper, lower, then the two extra bits
  wire [OUT_W-1:0] pattern_word = OUT_W'({pattern_upper_bits_r,
                                          pattern_lower_bits_r,
                                          pattern_extra_bit_a_r,
                                          pattern_extra_bit_b_r});

  // Per-channel output select, zero while napped or asleep
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [OUT_W-1:0] out_r;
      wire  [OUT_W-1:0] data_word =
        {sample_in[ch*DATA_W +: DATA_W], {EXTRA_W{1'b0}}};
      wire  [OUT_W-1:0] sel_word =
        pat_en_r ? pattern_word : data_word; // see R8, R9, R10, R11
      wire              idle = sleep_nxt | nap_nxt[ch];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) out_r <= '0;
        else out_r <= idle ? '0 : sel_word; // see R1, R2
      end
      assign sample_out[ch*OUT_W +: OUT_W] = out_r;
    end
  endgenerate

  // ==========================================================
  // Registered control outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_nap                 <= '0;
      converter_sleep             <= 1'b0;
      soft_reset_busy             <= 1'b0;
      driver_current_select       <= 3'b000;
      driver_current_ua           <= 13'h0DAC;
      current_code_reserved       <= 1'b0;
      internal_termination_enable <= 1'b0;
      output_driver_disable       <= 1'b0;
      lane_serialization_select   <= 3'b000;
      two_lane_mode               <= 1'b1;
      serial_width                <= 5'd16;
      lane_code_unused            <= 1'b0;
      pattern_output_enable       <= 1'b0;
    end else begin
      channel_nap                 <= nap_nxt; // see R1, R16
      converter_sleep             <= sleep_nxt; // see R2, R14
      soft_reset_busy             <= srst_busy | srst_go;
      driver_current_select       <= cur_code;
      driver_current_ua           <= cur_ua_nxt; // see R3, R4
      current_code_reserved       <= cur_reserved;
      internal_termination_enable <= om_r[`TERM_BIT]; // see R5
      output_driver_disable       <= om_r[`OUTPUT_DRIVER_DISABLE_BIT]; // see R15
      lane_serialization_select   <= lane_code;
      two_lane_mode               <= two_lane_nxt; // see R6, R7
      serial_width                <= width_nxt;
      lane_code_unused            <= lane_unused;
      pattern_output_enable       <= pat_en_r; // see R8
    end
  end

  // Open-drain read-back pin, pulls low only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      sdo_out <= 1'b0;
      sdo_oe  <= sdo_low; // see R13
    end
  end

endmodule

// ### verification/adc_mode_control_registers_assertions.sv
// Port-level assertions for the mode-control register bank
`timescale 1ns/1ps

module adc_mode_checker #(
  parameter int CHANNELS = 4,
  parameter int DATA_W   = 12,
  parameter int EXTRA_W  = 2
)
(
  // Clock, reset and serial pins
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       sdi,
  input wire logic       sdo_out,
  input wire logic       sdo_oe,
  // Sample paths
  input wire logic [CHANNELS*DATA_W-1:0]           sample_in,
  input wire logic [CHANNELS*(DATA_W+EXTRA_W)-1:0] sample_out,
  // Power control
  input wire logic [CHANNELS-1:0] channel_nap,
  input wire logic                converter_sleep,
  input wire logic                soft_reset_busy,
  // Driver, lane and pattern control
  input wire logic [2:0]  driver_current_select,
  input wire logic [12:0] driver_current_ua,
  input wire logic        current_code_reserved,
  input wire logic        internal_termination_enable,
  input wire logic        output_driver_disable,
  input wire logic [2:0]  lane_serialization_select,
  input wire logic        two_lane_mode,
  input wire logic [4:0]  serial_width,
  input wire logic        lane_code_unused,
  input wire logic        pattern_output_enable
);
  localparam int LW = DATA_W + EXTRA_W;

  // ============
  // Bank clock domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Drive current in microamps per select code
  function automatic logic [12:0] ua_of(input logic [2:0] c);
    case (c)
      3'h1: return 13'h0FA0;
      3'h2: return 13'h1194;
      3'h4: return 13'h0BB8;
      3'h5: return 13'h09C4;
      3'h6: return 13'h0834;
      3'h7: return 13'h06D6;
      default: return 13'h0DAC;
    endcase
  endfunction

  // Serialization width per lane code
  function automatic logic [4:0] w_of(input logic [2:0] c);
    case (c)
      3'h1, 3'h5: return 5'h0E;
      3'h2: return 5'h0C;
      default: return 5'h10;
    endcase
  endfunction

  // Channel outputs should carry converted data
  logic quiet;
  assign quiet = !pattern_output_enable && channel_nap == '0 &&
                 !converter_sleep;

  // ============
  // Assertions
  current_decode_a: assert property (
    $stable(driver_current_select) |->
    driver_current_ua == ua_of(driver_current_select) &&
    current_code_reserved == (driver_current_select == 3'h3))
    else $error("drive current decode wrong");
  lane_decode_a: assert property (
    $stable(lane_serialization_select) |->
    two_lane_mode == (lane_serialization_select < 3'h5) &&
    serial_width == w_of(lane_serialization_select) &&
    lane_code_unused == (lane_serialization_select inside {3'h3, 3'h4}))
    else $error("lane decode wrong");
  sleep_gates_nap_a: assert property (
    converter_sleep && $past(converter_sleep) |-> channel_nap == '0)
    else $error("nap shown while asleep");
  normal_path_a: assert property (
    quiet && $past(quiet) && $past(rst_n) |->
    sample_out[LW-1:0] == {$past(sample_in[DATA_W-1:0]), 2'b00})
    else $error("sample not passed through");
  reset_sleep_a: assert property (
    soft_reset_busy && $past(soft_reset_busy) |-> converter_sleep)
    else $error("no sleep during soft reset");
  reset_length_a: assert property (
    $rose(soft_reset_busy) |-> soft_reset_busy [*8] ##[1:12] !soft_reset_busy)
    else $error("soft reset length wrong");
  reset_clears_a: assert property (
    $fell(soft_reset_busy) |-> {driver_current_select, channel_nap,
    lane_serialization_select, pattern_output_enable,
    internal_termination_enable, output_driver_disable} == '0)
    else $error("registers not cleared by soft reset");
  sdo_idle_a: assert property (
    cs_n [*4] |-> !sdo_oe)
    else $error("data line pulled while deselected");

  // Main scenarios reached
  cover property (pattern_output_enable && channel_nap != '0);
  cover property ($rose(soft_reset_busy));
  cover property (sdo_oe && !cs_n);
endmodule

// ### verification/serial_host_model.sv
// Behavioural serial configuration host driving the bank's pins
`timescale 1ns/1ps

module serial_host_model (
  // Clock
  input  wire logic clock,
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo_wire
);
  // Clocks per serial clock phase, above the two-clock minimum
  localparam int PHASE = 4;

  // Deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b1;
  end

  // ============
  // One framed word; under 16 bits aborts, over 16 adds ignored rises
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [7:0] data, input int bits,
                      output logic [7:0] rd);
    logic [17:0] word;
    word = {rw, addr, data, 2'b10};
    rd   = 8'h00;
    cs_n <= 1'b0;
    repeat (PHASE) @(posedge clock);
    for (int i = 0; i < bits; i++) begin
      sdi <= word[17-i];
      repeat (PHASE) @(posedge clock);
      sck <= 1'b1;
      // Read bit launched on the last fall, taken at this rise
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo_wire};
      repeat (PHASE) @(posedge clock);
      sck <= 1'b0;
    end
    repeat (PHASE) @(posedge clock);
    cs_n <= 1'b1;
    sdi  <= ~sdi; // Released line shows the inverse of its last bit
    repeat (PHASE) @(posedge clock);
  endtask
endmodule

// ### verification/adc_mode_control_registers_tb_top.sv
// Self-checking bench for the mode-control register bank
`timescale 1ns/1ps
`include "adc_mode_consts.svh"

module adc_mode_control_registers_tb_top;
  // Clock, reset, pins and outputs
  logic        clock = 1'b0;
  logic        rst_n;
  logic        cs_n;
  logic        sck;
  logic        sdi;
  logic        sdo_out;
  logic        sdo_oe;
  logic [47:0] sample_in;
  logic [55:0] sample_out;
  logic [3:0]  channel_nap;
  logic        converter_sleep;
  logic        soft_reset_busy;
  logic [2:0]  driver_current_select;
  logic [12:0] driver_current_ua;
  logic        current_code_reserved;
  logic        internal_termination_enable;
  logic        output_driver_disable;
  logic [2:0]  lane_serialization_select;
  logic        two_lane_mode;
  logic [4:0]  serial_width;
  logic        lane_code_unused;
  logic        pattern_output_enable;
  wire         sdo_wire = sdo_oe ? sdo_out : 1'b1;
  // Shadow registers, random state and counters
  logic [4:0]  pd;
  logic [7:0]  om;
  logic [7:0]  ph;
  logic [7:0]  pl;
  logic [7:0]  v;
  logic [6:0]  a;
  logic [15:0] rnd;
  int          fails = 0;
  int          total_checks = 0;

  // Device and host
  adc_mode_control_registers uut (
    .clock, .rst_n, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe, .sample_in,
    .sample_out, .channel_nap, .converter_sleep, .soft_reset_busy,
    .driver_current_select, .driver_current_ua, .current_code_reserved,
    .internal_termination_enable, .output_driver_disable,
    .lane_serialization_select, .two_lane_mode, .serial_width,
    .lane_code_unused, .pattern_output_enable
  );
  serial_host_model host (.clock, .cs_n, .sck, .sdi, .sdo_wire);

  // 125 MHz clock
  always #4 clock = ~clock;

  // ============
  // Expectations
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [12:0] exp_ua(input logic [2:0] c);
    case (c)
      3'h1: return 13'h0FA0;
      3'h2: return 13'h1194;
      3'h4: return 13'h0BB8;
      3'h5: return 13'h09C4;
      3'h6: return 13'h0834;
      3'h7: return 13'h06D6;
      default: return 13'h0DAC;
    endcase
  endfunction
  function automatic logic [4:0] exp_w(input logic [2:0] c);
    case (c)
      3'h1, 3'h5: return 5'h0E;
      3'h2: return 5'h0C;
      default: return 5'h10;
    endcase
  endfunction
  function automatic logic [13:0] exp_ch(input int c);
    if (pd[4] || pd[c]) return 14'h0000;
    if (ph[7]) return {ph[5:0], pl};
    return {sample_in[c*12+:12], 2'b00};
  endfunction
  function automatic logic [7:0] exp_rb(input logic [6:0] r);
    case (r)
      7'h01: return {3'h0, pd};
      7'h02: return om;
      7'h03: return ph;
      7'h04: return pl;
      default: return 8'h00;
    endcase
  endfunction

  // ============
  // Compare, report and access tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_out();
    logic [55:0] e;
    for (int c = 0; c < 4; c++) e[c*14+:14] = exp_ch(c);
    check(sample_out, e);
    check(channel_nap, pd[4] ? 4'h0 : pd[3:0]);
    check(converter_sleep, pd[4]);
    check(driver_current_select, om[7:5]);
    check(driver_current_ua, exp_ua(om[7:5]));
    check(current_code_reserved, om[7:5] == 3'h3);
    check(internal_termination_enable, om[4]);
    check(output_driver_disable, om[3]);
    check(lane_serialization_select, om[2:0]);
    check(two_lane_mode, om[2:0] < 3'h5);
    check(serial_width, exp_w(om[2:0]));
    check(lane_code_unused, om[2:0] inside {3'h3, 3'h4});
    check(pattern_output_enable, ph[7]);
  endtask
  task automatic wr(input logic [6:0] r, input logic [7:0] d, input int n);
    rnd = lfsr_next(rnd);
    sample_in <= {rnd, lfsr_next(rnd), ~rnd};
    host.xfer(1'b0, r, d, n, v);
    if (n >= 16) begin
      if (r == 7'h01) pd = d[4:0];
      if (r == 7'h02) om = d;
      if (r == 7'h03) ph = d & 8'hBF;
      if (r == 7'h04) pl = d;
    end
    chk_out();
  endtask
  task automatic rd_chk(input logic [6:0] r);
    rnd = lfsr_next(rnd);
    host.xfer(1'b1, r, rnd[7:0], 16, v);
    check(v, exp_rb(r));
    chk_out();
  endtask
  task automatic srst();
    int n;
    host.xfer(1'b0, `ADDR_SOFT_RESET, 8'h80, 16, v);
    for (n = 0; n < 64 && soft_reset_busy !== 1'b0; n++) @(posedge clock);
    if (n == 64) begin
      fails++;
      final_report();
    end
    {pd, om, ph, pl} = '0;
    chk_out();
    rd_chk(`ADDR_SOFT_RESET);
  endtask

  // ============
  // Main sequence
  initial begin
    rst_n = 1'b0;
    sample_in = '0;
    rnd = 16'h8639;
    {pd, om, ph, pl} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk_out();
    srst();
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      wr(`ADDR_OUTPUT_MODE, {i[2:0], rnd[1:0], 3'(7 - i)}, 16);
      rd_chk(`ADDR_OUTPUT_MODE);
    end
    wr(`ADDR_POWER_DOWN, 8'h0F, 16);
    wr(`ADDR_POWER_DOWN, 8'hFA, 16);
    wr(`ADDR_PATTERN_HIGH, 8'hFF, 16);
    wr(`ADDR_PATTERN_LOW, 8'h03, 16);
    wr(`ADDR_POWER_DOWN, 8'h05, 16);
    rd_chk(`ADDR_PATTERN_HIGH);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr_next(rnd);
      a = 7'(rnd[1:0] + 1);
      wr(a, rnd[15:8], 16);
      rd_chk(a);
    end
    wr(`ADDR_OUTPUT_MODE, 8'hA5, 12);
    wr(`ADDR_PATTERN_LOW, 8'h5C, 18);
    wr(7'h05, 8'hFF, 16);
    rd_chk(7'h05);
    rd_chk(7'h7F);
    wr(`ADDR_OUTPUT_MODE, 8'hFF, 16);
    srst();
    final_report();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule

bind adc_mode_control_registers adc_mode_checker #(
  .CHANNELS(CHANNELS), .DATA_W(DATA_W), .EXTRA_W(EXTRA_W)
) chk (
  .clock, .rst_n, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe, .sample_in,
  .sample_out, .channel_nap, .converter_sleep, .soft_reset_busy,
  .driver_current_select, .driver_current_ua, .current_code_reserved,
  .internal_termination_enable, .output_driver_disable,
  .lane_serialization_select, .two_lane_mode, .serial_width,
  .lane_code_unused, .pattern_output_enable
);
